// file: shared/rsc_defines.vh
// Constants shared by the RTU slave response checker files
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
// ==========================================================
// CRC-16
`define RSC_CRC_INIT     16'hFFFF
`define RSC_CRC_POLY     16'hA001
// ==========================================================
// Addressing and frame lengths
`define RSC_ADDR_BCAST   8'h00
`define RSC_MAX_LEN      9'h100
`define RSC_MIN_LEN      9'h004
`define RSC_FIX_LEN      9'h008
`define RSC_WM_MIN_LEN   9'h00B
`define RSC_WM_MAX_LEN   9'h029
`define RSC_WM_HDR_LEN   9'h009
`define RSC_HDR_BYTES    3'h7
// ==========================================================
// Function codes
`define RSC_FC_READ      8'h03
`define RSC_FC_WRITE1    8'h06
`define RSC_FC_DIAG      8'h08
`define RSC_FC_WRITEN    8'h10
`define RSC_FC_EXC_BIT   8'h80
`define RSC_DIAG_SUB_OK  16'h0000
// ==========================================================
// Register range and count limits
`define RSC_REG_LIMIT    17'h02000
`define RSC_CNT_MAX      16'h0011
// ==========================================================
// Exception codes
`define RSC_EXC_FUNC     8'h01
`define RSC_EXC_ADDR     8'h02
`define RSC_EXC_DATA     8'h03
`define RSC_EXC_SLAVE    8'h04
// ==========================================================
// Internal communication error codes
`define RSC_ERR_FUNC     8'h01
`define RSC_ERR_ADDR     8'h88
`define RSC_ERR_UIF      8'h89
`define RSC_ERR_NV       8'h8A
`define RSC_ERR_DATA     8'h8C
`define RSC_ERR_DIS      8'h8D
// ==========================================================
// Outcome codes
`define RSC_OUT_NORMAL   2'h0
`define RSC_OUT_NONE     2'h1
`define RSC_OUT_EXC      2'h2
`endif

// file: design/rsc_crc16.v
// Byte-wide CRC-16 accumulator
`timescale 1ns/10ps
`include "rsc_defines.vh"
module rsc_crc16 (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        ce,
    input  wire        init,
    input  wire        upd,
    input  wire [7:0]  din,
    output reg  [15:0] crc_reg
);
    reg     [15:0] crc_next;
    integer        i;

    // ==========================================================
    // Eight right shifts, polynomial folded in on a shifted-out one
    always @* begin
        crc_next = crc_reg ^ {8'h00, din};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_next[0]) begin
                crc_next = (crc_next >> 1) ^ `RSC_CRC_POLY;
            end else begin
                crc_next = crc_next >> 1;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_reg <= `RSC_CRC_INIT;
        end else if (ce) begin
            if (init) begin
                crc_reg <= `RSC_CRC_INIT;
            end else if (upd) begin
                crc_reg <= crc_next;
            end
        end
    end
endmodule // rsc_crc16

// file: design/rsc_decode.v
// Classifies a well-formed query into accept or exception with codes
`timescale 1ns/10ps
`include "rsc_defines.vh"
module rsc_decode (
    input  wire [7:0]  func,
    input  wire [15:0] word_a,
    input  wire [15:0] word_b,
    input  wire [7:0]  bcnt,
    input  wire [8:0]  len,
    input  wire        uif_busy,
    input  wire        nv_busy,
    input  wire        nv_alarm,
    input  wire        range_err,
    input  wire        cmd_dis,
    output reg         exc,
    output reg  [7:0]  exc_code,
    output reg  [7:0]  err_code
);
    reg        supported;
    reg        len_bad;
    reg        cnt_bad;
    reg [16:0] reg_end;

    always @* begin
        supported = (func == `RSC_FC_READ) || (func == `RSC_FC_WRITE1) ||
                    (func == `RSC_FC_DIAG) || (func == `RSC_FC_WRITEN);
        if (func == `RSC_FC_WRITEN) begin
            len_bad = (len < `RSC_WM_MIN_LEN) || (len > `RSC_WM_MAX_LEN) ||
                      (len != `RSC_WM_HDR_LEN + {1'b0, bcnt});
        end else begin
            len_bad = (len != `RSC_FIX_LEN);
        end
        cnt_bad = ((func == `RSC_FC_READ) || (func == `RSC_FC_WRITEN)) &&
                  ((word_b == 16'h0000) || (word_b > `RSC_CNT_MAX));
        if ((func == `RSC_FC_WRITEN) && ({8'h00, bcnt} != {word_b[14:0], 1'b0})) begin
            cnt_bad = 1'b1;
        end
        if (func == `RSC_FC_WRITE1) begin
            reg_end = {1'b0, word_a} + 17'h00001;
        end else begin
            reg_end = {1'b0, word_a} + {1'b0, word_b};
        end
        exc      = 1'b1;
        exc_code = `RSC_EXC_SLAVE;
        err_code = 8'h00;
        if (!supported ||
            ((func == `RSC_FC_DIAG) && (word_a != `RSC_DIAG_SUB_OK))) begin
            exc_code = `RSC_EXC_FUNC;
            err_code = `RSC_ERR_FUNC;
        end else if (len_bad || cnt_bad) begin
            exc_code = `RSC_EXC_DATA;
            err_code = `RSC_ERR_DATA;
        end else if ((func != `RSC_FC_DIAG) && (reg_end >= `RSC_REG_LIMIT)) begin
            exc_code = `RSC_EXC_ADDR;
            err_code = `RSC_ERR_ADDR;
        end else if (uif_busy) begin
            err_code = `RSC_ERR_UIF;
        end else if (nv_busy || nv_alarm) begin
            err_code = `RSC_ERR_NV;
        end else if (range_err && (func != `RSC_FC_READ) && (func != `RSC_FC_DIAG)) begin
            err_code = `RSC_ERR_DATA;
        end else if (cmd_dis) begin
            err_code = `RSC_ERR_DIS;
        end else begin
            exc      = 1'b0;
            exc_code = 8'h00;
        end
    end
endmodule // rsc_decode

// file: design/rsc_resp_checker.v
// RTU slave query checker and response sequencer
// Functional notes
// - Each query ends as normal response, no response, or exception response.
// - Response is address, function, data bytes, then 16-bit check field.
// - Valid unicast query for this slave is executed, then answered.
// - Stop bit sampled 0 in any character: discard query, no reply.
// - Parity failure in any character: discard query silently.
// - CRC-16 over received message must match check field, else discard.
// - Message longer than 256 bytes is discarded without reply.
// - Broadcast query is executed but never answered; the code executes only error-free 06h and 10h broadcasts.
// - Address neither ours nor broadcast: ignore query.
// - Exception frame: address, function, one exception code, 16-bit check.
// - Exception function byte is query function plus 80h.
// - Unsupported function or diagnosis sub-function not 00h: code 01h, log 01h.
// - Address beyond 1FFFh or end reaching 2000h: code 02h, log 88h.
// - Register count zero or above 17: code 03h, log 8Ch.
// - Byte count not twice register count: invalid-data exception.
// - Data length outside function range: invalid-data exception.
// - User-interface link busy: slave-error exception, log 89h.
// - Nonvolatile busy or memory alarm: slave-error exception, log 8Ah.
// - Written value outside setting range: slave-error exception, log 8Ch.
// - Command disabled: slave-error exception, log 8Dh.
// - CRC starts FFFFh, eight right shifts per byte, XOR A001h on one out.
// - Address zero is broadcast; nonzero selects one slave.
// - Only functions 03h, 06h, 08h and 10h are supported.
`timescale 1ns/10ps
`include "rsc_defines.vh"
module rsc_resp_checker (
    input  wire        SYS_CLK,
    input  wire        RST_B,
    input  wire        CLK_EN,
    input  wire        RX_VALID,
    input  wire [7:0]  RX_DATA,
    input  wire        RX_FRAME_ERR,
    input  wire        RX_PARITY_ERR,
    input  wire        RX_END,
    input  wire [7:0]  SLAVE_ADDR,
    input  wire        UIF_BUSY,
    input  wire        NONVOLATILE_BUSY_FLAG,
    input  wire        NV_MEM_ALARM,
    input  wire        RANGE_ERR,
    input  wire        CMD_DISABLED,
    output wire        OP_REQ,
    input  wire        OP_ACK,
    output wire [7:0]  OP_FUNC,
    output wire [15:0] OP_ADDR,
    output wire [15:0] OP_WORD,
    output wire        RD_REQ,
    output wire [4:0]  RD_IDX,
    input  wire        RD_ACK,
    input  wire [15:0] RD_DATA,
    output wire        TX_VALID,
    output wire [7:0]  TX_DATA,
    input  wire        TX_READY,
    output wire        BUSY,
    output wire [1:0]  OUTCOME,
    output wire        OUTCOME_STB,
    output wire [7:0]  COMM_ERR_CODE,
    output wire        COMM_ERR_STB
);
    localparam [2:0] ST_RX    = 3'h0;
    localparam [2:0] ST_CHECK = 3'h1;
    localparam [2:0] ST_EXEC  = 3'h2;
    localparam [2:0] ST_LOAD  = 3'h3;
    localparam [2:0] ST_SEND  = 3'h4;
    localparam [1:0] K_ECHO   = 2'h0;
    localparam [1:0] K_READ   = 2'h1;
    localparam [1:0] K_EXC    = 2'h2;

    reg  [2:0]  state_reg;
    reg  [8:0]  rx_cnt_reg;
    reg         frm_err_reg;
    reg         par_err_reg;
    reg  [7:0]  hdr_reg [0:6];
    reg         bcast_reg;
    reg  [1:0]  kind_reg;
    reg  [7:0]  exc_code_reg;
    reg  [5:0]  tx_idx_reg;
    reg  [5:0]  tx_len_reg;
    reg  [7:0]  tx_data_reg;
    reg         tx_valid_reg;
    reg  [15:0] rd_word_reg;
    reg         word_ok_reg;
    reg  [4:0]  rd_idx_reg;
    reg  [1:0]  outcome_reg;
    reg         outcome_stb_reg;
    reg  [7:0]  err_code_reg;
    reg         err_stb_reg;
    reg  [7:0]  byte_next;
    reg         need_word;
    wire [15:0] crc_rx;
    wire [15:0] crc_tx;
    wire        dec_exc;
    wire [7:0]  dec_exc_code;
    wire [7:0]  dec_err_code;
    wire [15:0] word_a;
    wire [15:0] word_b;
    wire        rx_take;
    wire        tx_take;
    wire        crc_phase;
    wire [5:0]  data_off;

    assign word_a   = {hdr_reg[2], hdr_reg[3]};
    assign word_b   = {hdr_reg[4], hdr_reg[5]};
    assign rx_take  = (state_reg == ST_RX) && RX_VALID;
    assign tx_take  = (state_reg == ST_SEND) && TX_READY;
    assign crc_phase = (tx_idx_reg >= tx_len_reg - 6'h02);
    assign data_off = tx_idx_reg - 6'h03;

    assign OP_REQ        = (state_reg == ST_EXEC);
    assign OP_FUNC       = hdr_reg[1];
    assign OP_ADDR       = word_a;
    assign OP_WORD       = word_b;
    assign RD_REQ        = (state_reg == ST_LOAD) && need_word;
    assign RD_IDX        = rd_idx_reg;
    assign TX_VALID      = tx_valid_reg;
    assign TX_DATA       = tx_data_reg;
    assign BUSY          = (state_reg != ST_RX);
    assign OUTCOME       = outcome_reg;
    assign OUTCOME_STB   = outcome_stb_reg;
    assign COMM_ERR_CODE = err_code_reg;
    assign COMM_ERR_STB  = err_stb_reg;

    // ==========================================================
    // CRC engines: one over the received frame, one over the reply
    rsc_crc16 u_crc_rx (
        .clk     (SYS_CLK),
        .rst_b   (RST_B),
        .ce      (CLK_EN),
        .init    (state_reg == ST_CHECK),
        .upd     (rx_take),
        .din     (RX_DATA),
        .crc_reg (crc_rx)
    );

    rsc_crc16 u_crc_tx (
        .clk     (SYS_CLK),
        .rst_b   (RST_B),
        .ce      (CLK_EN),
        .init    (state_reg == ST_CHECK),
        .upd     (tx_take && !crc_phase),
        .din     (tx_data_reg),
        .crc_reg (crc_tx)
    );

    // ==========================================================
    // Query classification
    rsc_decode u_decode (
        .func      (hdr_reg[1]),
        .word_a    (word_a),
        .word_b    (word_b),
        .bcnt      (hdr_reg[6]),
        .len       (rx_cnt_reg),
        .uif_busy  (UIF_BUSY),
        .nv_busy   (NONVOLATILE_BUSY_FLAG),
        .nv_alarm  (NV_MEM_ALARM),
        .range_err (RANGE_ERR),
        .cmd_dis   (CMD_DISABLED),
        .exc       (dec_exc),
        .exc_code  (dec_exc_code),
        .err_code  (dec_err_code)
    );

    // ==========================================================
    // Next reply byte
    always @* begin
        need_word = (kind_reg == K_READ) && !crc_phase && (tx_idx_reg >= 6'h03) &&
                    !data_off[0] && !word_ok_reg;
        byte_next = hdr_reg[0];
        if (crc_phase) begin
            byte_next = tx_idx_reg[0] == tx_len_reg[0] ? crc_tx[7:0] : crc_tx[15:8];
        end else if (tx_idx_reg == 6'h01) begin
            byte_next = (kind_reg == K_EXC) ? (hdr_reg[1] | `RSC_FC_EXC_BIT) : hdr_reg[1];
        end else if (tx_idx_reg != 6'h00) begin
            case (kind_reg)
                K_EXC: begin
                    byte_next = exc_code_reg;
                end
                K_READ: begin
                    if (tx_idx_reg == 6'h02) begin
                        byte_next = {word_b[6:0], 1'b0};
                    end else begin
                        byte_next = data_off[0] ? rd_word_reg[7:0] : rd_word_reg[15:8];
                    end
                end
                default: begin
                    byte_next = hdr_reg[tx_idx_reg[2:0]];
                end
            endcase
        end
    end

    // ==========================================================
    // Receive, check, execute and reply sequencer
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg       <= ST_RX;
            rx_cnt_reg      <= 9'h000;
            frm_err_reg     <= 1'b0;
            par_err_reg     <= 1'b0;
            hdr_reg[0]      <= 8'h00;
            hdr_reg[1]      <= 8'h00;
            hdr_reg[2]      <= 8'h00;
            hdr_reg[3]      <= 8'h00;
            hdr_reg[4]      <= 8'h00;
            hdr_reg[5]      <= 8'h00;
            hdr_reg[6]      <= 8'h00;
            bcast_reg       <= 1'b0;
            kind_reg        <= K_ECHO;
            exc_code_reg    <= 8'h00;
            tx_idx_reg      <= 6'h00;
            tx_len_reg      <= 6'h00;
            tx_data_reg     <= 8'h00;
            tx_valid_reg    <= 1'b0;
            rd_word_reg     <= 16'h0000;
            word_ok_reg     <= 1'b0;
            rd_idx_reg      <= 5'h00;
            outcome_reg     <= `RSC_OUT_NONE;
            outcome_stb_reg <= 1'b0;
            err_code_reg    <= 8'h00;
            err_stb_reg     <= 1'b0;
        end else if (CLK_EN) begin
            outcome_stb_reg <= 1'b0;
            err_stb_reg     <= 1'b0;
            case (state_reg)
                ST_RX: begin
                    if (rx_take) begin
                        if (rx_cnt_reg < {6'h00, `RSC_HDR_BYTES}) begin
                            hdr_reg[rx_cnt_reg[2:0]] <= RX_DATA;
                        end
                        if (rx_cnt_reg <= `RSC_MAX_LEN) begin
                            rx_cnt_reg <= rx_cnt_reg + 9'h001;
                        end
                        if (RX_FRAME_ERR) begin
                            frm_err_reg <= 1'b1;
                        end
                        if (RX_PARITY_ERR) begin
                            par_err_reg <= 1'b1;
                        end
                    end
                    if (RX_END && (rx_cnt_reg != 9'h000)) begin
                        state_reg <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    bcast_reg    <= (hdr_reg[0] == `RSC_ADDR_BCAST);
                    exc_code_reg <= dec_exc_code;
                    tx_idx_reg   <= 6'h00;
                    word_ok_reg  <= 1'b0;
                    rd_idx_reg   <= 5'h00;
                    rx_cnt_reg   <= 9'h000;
                    frm_err_reg  <= 1'b0;
                    par_err_reg  <= 1'b0;
                    if (frm_err_reg || par_err_reg || (crc_rx != 16'h0000) ||
                        (rx_cnt_reg > `RSC_MAX_LEN) || (rx_cnt_reg < `RSC_MIN_LEN)) begin
                        state_reg       <= ST_RX;
                        outcome_reg     <= `RSC_OUT_NONE;
                        outcome_stb_reg <= 1'b1;
                    end else if ((hdr_reg[0] != `RSC_ADDR_BCAST) &&
                                 (hdr_reg[0] != SLAVE_ADDR)) begin
                        state_reg       <= ST_RX;
                        outcome_reg     <= `RSC_OUT_NONE;
                        outcome_stb_reg <= 1'b1;
                    end else if (dec_exc) begin
                        err_code_reg <= dec_err_code;
                        err_stb_reg  <= 1'b1;
                        kind_reg     <= K_EXC;
                        tx_len_reg   <= 6'h05;
                        if (hdr_reg[0] == `RSC_ADDR_BCAST) begin
                            state_reg       <= ST_RX;
                            outcome_reg     <= `RSC_OUT_NONE;
                            outcome_stb_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_LOAD;
                        end
                    end else if (hdr_reg[1] == `RSC_FC_READ) begin
                        kind_reg   <= K_READ;
                        tx_len_reg <= 6'h05 + {word_b[4:0], 1'b0};
                        if (hdr_reg[0] == `RSC_ADDR_BCAST) begin
                            state_reg       <= ST_RX;
                            outcome_reg     <= `RSC_OUT_NONE;
                            outcome_stb_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_LOAD;
                        end
                    end else begin
                        kind_reg   <= K_ECHO;
                        tx_len_reg <= 6'h08;
                        if (hdr_reg[1] == `RSC_FC_DIAG) begin
                            state_reg <= (hdr_reg[0] == `RSC_ADDR_BCAST) ? ST_RX : ST_LOAD;
                            if (hdr_reg[0] == `RSC_ADDR_BCAST) begin
                                outcome_reg     <= `RSC_OUT_NONE;
                                outcome_stb_reg <= 1'b1;
                            end
                        end else begin
                            state_reg <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    if (OP_ACK) begin
                        if (bcast_reg) begin
                            state_reg       <= ST_RX;
                            outcome_reg     <= `RSC_OUT_NONE;
                            outcome_stb_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    if (need_word) begin
                        if (RD_ACK) begin
                            rd_word_reg <= RD_DATA;
                            word_ok_reg <= 1'b1;
                        end
                    end else begin
                        tx_data_reg  <= byte_next;
                        tx_valid_reg <= 1'b1;
                        state_reg    <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (TX_READY) begin
                        tx_valid_reg <= 1'b0;
                        tx_idx_reg   <= tx_idx_reg + 6'h01;
                        if ((kind_reg == K_READ) && !crc_phase &&
                            (tx_idx_reg >= 6'h04) && data_off[0]) begin
                            word_ok_reg <= 1'b0;
                            rd_idx_reg  <= rd_idx_reg + 5'h01;
                        end
                        if (tx_idx_reg == tx_len_reg - 6'h01) begin
                            state_reg       <= ST_RX;
                            outcome_reg     <= (kind_reg == K_EXC) ? `RSC_OUT_EXC
                                                                   : `RSC_OUT_NORMAL;
                            outcome_stb_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_LOAD;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_RX;
                end
            endcase
        end
    end
endmodule // rsc_resp_checker

// file: bench/rsc_resp_props.sv
// Port-level properties of the response checker
`timescale 1ns/10ps
module rsc_resp_props (
    input        SYS_CLK, RST_B, CLK_EN, OP_REQ, OP_ACK, RD_REQ, RD_ACK,
    input        TX_VALID, TX_READY, BUSY, OUTCOME_STB, COMM_ERR_STB,
    input [4:0]  RD_IDX,
    input [7:0]  TX_DATA, COMM_ERR_CODE,
    input [1:0]  OUTCOME
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("reply byte moved early");
    a_tx_gap: assert property (TX_VALID && TX_READY && CLK_EN |=> !TX_VALID)
        else $error("no gap after a byte");
    a_op_hold: assert property (OP_REQ && !OP_ACK |=> OP_REQ)
        else $error("execute request dropped");
    a_rd_hold: assert property (RD_REQ && !RD_ACK |=> RD_REQ && $stable(RD_IDX))
        else $error("read request moved");
    a_req_excl: assert property (!(OP_REQ && RD_REQ))
        else $error("execute and read together");
    a_idle_quiet: assert property (!BUSY |-> !TX_VALID && !OP_REQ && !RD_REQ)
        else $error("activity while idle");
    a_outcome_one: assert property (OUTCOME_STB && CLK_EN |-> OUTCOME != 2'h3 ##1 !OUTCOME_STB)
        else $error("bad outcome strobe");
    a_err_code: assert property (COMM_ERR_STB |-> COMM_ERR_CODE inside
        {8'h01, 8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D})
        else $error("bad error code");
    a_busy_ends: assert property ($rose(BUSY) |-> ##[1:1000] !BUSY)
        else $error("query never finished");
    c_exc: cover property (OUTCOME_STB && OUTCOME == 2'h2);
    c_norm: cover property (OUTCOME_STB && OUTCOME == 2'h0);
    c_dis: cover property (COMM_ERR_STB && COMM_ERR_CODE == 8'h8D);
endmodule // rsc_resp_props
bind rsc_resp_checker rsc_resp_props i_props (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .CLK_EN(CLK_EN), .OP_REQ(OP_REQ), .OP_ACK(OP_ACK), .RD_REQ(RD_REQ), .RD_ACK(RD_ACK),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .BUSY(BUSY), .OUTCOME_STB(OUTCOME_STB),
    .COMM_ERR_STB(COMM_ERR_STB), .RD_IDX(RD_IDX), .TX_DATA(TX_DATA),
    .COMM_ERR_CODE(COMM_ERR_CODE), .OUTCOME(OUTCOME));

// file: bench/rsc_master_model.sv
// Far-side model: takes response bytes, answers execute and read requests
`timescale 1ns/10ps
module rsc_master_model (
    input  logic        clk, clk_en, slow, op_req, rd_req, tx_valid,
    input  logic [4:0]  rd_idx,
    input  logic [7:0]  tx_data,
    output logic        op_ack = 0, rd_ack = 0, tx_ready = 0,
    output logic [15:0] rd_data
);
    logic       ph = 0;
    logic [7:0] got[$];
    int         n_op = 0;
    // Inverted unless acknowledged, so a stale word shows
    assign rd_data = rd_ack ? {8'hA5, 3'h0, rd_idx} : ~{8'hA5, 3'h0, rd_idx};
    always @(negedge clk) begin
        ph <= ~ph;
        tx_ready <= !slow || ph;
        op_ack <= op_req && (!slow || ph);
        rd_ack <= rd_req && (!slow || ph);
    end
    always @(posedge clk) begin
        if (clk_en && tx_valid && tx_ready) got.push_back(tx_data);
        if (clk_en && op_req && op_ack) n_op++;
    end
endmodule // rsc_master_model

// file: bench/tb_rsc_resp_checker.sv
// Self-checking bench of the response checker
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected %0t got %h expected %h", $time, a, b); end end
module tb_rsc_resp_checker;
    logic SYS_CLK = 0, RST_B = 0, CLK_EN = 1, RX_VALID = 0, RX_FRAME_ERR = 0, RX_PARITY_ERR = 0;
    logic RX_END = 0, slow = 0, logged = 0;
    logic [7:0] RX_DATA = 8'h00, SLAVE_ADDR = 8'h01, lcode = 8'h00, fl = 8'h00;
    logic [7:0] q[$], e[$];
    wire OP_REQ, OP_ACK, RD_REQ, RD_ACK, TX_VALID, TX_READY, BUSY, OUTCOME_STB, COMM_ERR_STB;
    wire [7:0] OP_FUNC, TX_DATA, COMM_ERR_CODE;
    wire [15:0] OP_ADDR, OP_WORD, RD_DATA;
    wire [4:0] RD_IDX;
    wire [1:0] OUTCOME;
    int n_fail = 0, compares = 0;
    always #12.5 SYS_CLK = ~SYS_CLK;
    rsc_resp_checker i_dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
        .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_FRAME_ERR(RX_FRAME_ERR),
        .RX_PARITY_ERR(RX_PARITY_ERR), .RX_END(RX_END), .SLAVE_ADDR(SLAVE_ADDR),
        .UIF_BUSY(fl[4]), .NONVOLATILE_BUSY_FLAG(fl[3]),
        .NV_MEM_ALARM(fl[2]), .RANGE_ERR(fl[1]), .CMD_DISABLED(fl[0]),
        .OP_REQ(OP_REQ), .OP_ACK(OP_ACK), .OP_FUNC(OP_FUNC), .OP_ADDR(OP_ADDR),
        .OP_WORD(OP_WORD), .RD_REQ(RD_REQ), .RD_IDX(RD_IDX), .RD_ACK(RD_ACK),
        .RD_DATA(RD_DATA), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
        .BUSY(BUSY), .OUTCOME(OUTCOME), .OUTCOME_STB(OUTCOME_STB),
        .COMM_ERR_CODE(COMM_ERR_CODE), .COMM_ERR_STB(COMM_ERR_STB));
    rsc_master_model i_model (.clk(SYS_CLK), .clk_en(CLK_EN), .slow(slow), .op_req(OP_REQ),
        .rd_req(RD_REQ), .tx_valid(TX_VALID), .rd_idx(RD_IDX), .tx_data(TX_DATA),
        .op_ack(OP_ACK), .rd_ack(RD_ACK), .tx_ready(TX_READY), .rd_data(RD_DATA));
    always @(posedge SYS_CLK) if (COMM_ERR_STB) begin logged <= 1; lcode <= COMM_ERR_CODE; end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task automatic seal(ref logic [7:0] b[$]);
        logic [15:0] c = crc16(b);
        b = {b, c[7:0], c[15:8]};
    endtask
    task automatic go(input int fe, pe, input logic [1:0] eo, input logic [7:0] ec);
        i_model.got.delete();
        logged = 0;
        foreach (q[i]) begin
            @(negedge SYS_CLK);
            {RX_VALID, RX_DATA, RX_FRAME_ERR, RX_PARITY_ERR} = {1'b1, q[i], i == fe, i == pe};
        end
        @(negedge SYS_CLK);
        {RX_VALID, RX_FRAME_ERR, RX_PARITY_ERR, RX_END} = 4'h1;
        @(negedge SYS_CLK);
        RX_END = 0;
        for (int k = 0; OUTCOME_STB !== 1'b1 && k < 2000; k++) @(negedge SYS_CLK);
        `CHK(OUTCOME_STB, 1'b1)
        `CHK(OUTCOME, eo)
        `CHK(logged, ec != 8'h00)
        if (ec != 8'h00) `CHK(lcode, ec)
        `CHK(i_model.got.size(), e.size())
        foreach (e[i]) if (i < i_model.got.size()) `CHK(i_model.got[i], e[i])
        repeat (3) @(negedge SYS_CLK);
    endtask
    task automatic t_normal;
        int n0 = i_model.n_op;
        q = {8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h02}; seal(q);
        e = {8'h01, 8'h03, 8'h04, 8'hA5, 8'h00, 8'hA5, 8'h01}; seal(e);
        go(-1, -1, 2'h0, 8'h00);
        slow = 1;
        q = {8'h01, 8'h06, 8'h02, 8'h4B, 8'h00, 8'h50}; seal(q); e = q;
        go(-1, -1, 2'h0, 8'h00);
        q = {8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}; seal(q); e = q;
        go(-1, -1, 2'h0, 8'h00);
        q = {8'h01, 8'h10, 8'h02, 8'h42, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h03, 8'h20};
        e = q[0:5]; seal(q); seal(e);
        go(-1, -1, 2'h0, 8'h00);
        `CHK({OP_FUNC, OP_ADDR, OP_WORD}, 40'h10_0242_0002)
        slow = 0;
        `CHK(i_model.n_op, n0 + 2)
    endtask
    task automatic t_silent;
        int n0;
        q = {8'h01, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}; seal(q); e = {};
        go(2, -1, 2'h1, 8'h00);
        go(-1, 3, 2'h1, 8'h00);
        q[7] = ~q[7];
        go(-1, -1, 2'h1, 8'h00);
        n0 = i_model.n_op;
        q[0] = 8'h02; q = q[0:5]; seal(q);
        go(-1, -1, 2'h1, 8'h00);
        q[0] = 8'h00; q = q[0:5]; seal(q);
        go(-1, -1, 2'h1, 8'h00);
        `CHK(i_model.n_op, n0 + 1)
        q = {}; repeat (255) q.push_back(8'h01); seal(q);
        go(-1, -1, 2'h1, 8'h00);
    endtask
    task automatic t_exc;
        logic [7:0] f, x, r;
        logic [15:0] a, c;
        logic [63:0] tbl [11] = '{64'h05_0000_0001_00_01_01, 64'h08_0001_0000_00_01_01,
            64'h03_2000_0001_00_02_88, 64'h03_1FFF_0001_00_02_88, 64'h03_0000_0000_00_03_8C,
            64'h03_0000_0012_00_03_8C, 64'h06_0010_0001_10_04_89, 64'h06_0010_0001_08_04_8A,
            64'h06_0010_0001_04_04_8A, 64'h06_0010_0001_02_04_8C, 64'h06_0010_0001_01_04_8D};
        foreach (tbl[i]) begin
            {f, a, c, fl, x, r} = tbl[i];
            q = {8'h01, f, a[15:8], a[7:0], c[15:8], c[7:0]}; seal(q);
            e = {8'h01, f | 8'h80, x}; seal(e);
            go(-1, -1, 2'h2, r);
        end
        fl = 8'h00;
        q = {8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h03}; seal(q);
        e = {8'h01, 8'h90, 8'h03}; seal(e);
        go(-1, -1, 2'h2, 8'h8C);
        q = {8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00}; seal(q);
        e = {8'h01, 8'h83, 8'h03}; seal(e);
        go(-1, -1, 2'h2, 8'h8C);
    endtask
    task automatic stop_test;
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge SYS_CLK);
        @(negedge SYS_CLK) RST_B = 1;
        t_normal();
        t_silent();
        t_exc();
        stop_test();
    end
    initial begin
        #500000;
        n_fail++;
        stop_test();
    end
endmodule // tb_rsc_resp_checker
